// file: design/pma_mgmt_access.sv
`timescale 1ns/100ps
`include "pma_params.svh"

// Operation
// [RL1] PHY registers are 16 bits, reached only through management registers
// [RL2] 32 PHY addresses; unmapped writes ignored, unmapped reads give all ones
// [RL3] Host never writes reserved PHY addresses, ignores their read value
// [RL4] Five-bit index in select register picks target of every operation
// [RL5] Host writes select register bits 12 to 8 as one
// [RL6] Setting the read command starts one read and sets busy
// [RL7] Selected register read exactly once, copied into read data register
// [RL8] A read takes 25.6 us, then busy clears by itself
// [RL9] Host clears read command after busy clears, then fetches data
// [RL10] Read data bytes may be fetched in either order
// [RL11] PHY write replaces all 16 bits at once
// [RL12] Host loads write data low byte first, high byte second
// [RL13] Writing write data high byte launches write and sets busy
// [RL14] Target takes value after 25.6 us, then busy clears
// [RL15] While busy, host starts no scan, read or write
// [RL16] Scan command sets busy and reads back to back every 25.6 us
// [RL17] Invalid flag shows whether first read has completed
// [RL18] Scan updates give no indication; bytes may come from different reads
// [RL19] During a scan host neither writes data nor requests a read
// [RL20] Clearing scan command ends scan; busy clears once it has ended
// [RL21] Read data updated with both bytes together, held otherwise
module pma_mgmt_access (
	input  logic       mclk,
	input  logic       rst,
	input  logic [3:0] regAddr,
	input  logic       regWr,
	input  logic       regRd,
	input  logic [7:0] regWrData,
	output logic [7:0] regRdData_q
);

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	logic [`PMA_IDX_W-1:0]  phyRegIndex_q;
	logic [`PMA_IDX_W-1:0]  selReserved_q;
	logic [`PMA_IDX_W-1:0]  opIndex_q;
	logic                   cmdRead_q;
	logic                   cmdScan_q;
	logic                   readTaken_q;
	logic                   writePend_q;
	logic                   read_data_invalid_q;
	logic [15:0]            mgmtWriteData_q;
	logic [15:0]            mgmtReadData_q;
	logic [`PMA_CNT_W-1:0]  opCnt_q;
	logic [`PMA_CNT_W-1:0]  opCnt_d;
	pma_pkg::pma_state_type state_q;
	pma_pkg::pma_state_type state_d;

	logic                   selLoWr;
	logic                   selHiWr;
	logic                   cmdLoWr;
	logic                   wrLoWr;
	logic                   wrHiWr;
	logic                   busy;
	logic                   scanning;
	logic                   idle;
	logic                   opLast;
	logic                   startScan;
	logic                   startRead;
	logic                   startWrite;
	logic                   anyStart;
	logic                   rdUpdate;
	logic                   phyWrEn;
	logic                   phyHit;
	logic [15:0]            phyRdData;
	logic [7:0]             statusLo;
	logic [7:0]             cmdLo;
	logic [7:0]             rdByte;

	// ----------------------------------------------------------------
	// Host write decode
	// ----------------------------------------------------------------
	assign selLoWr = regWr && (regAddr == `PMA_ADDR_SEL_LO);
	assign selHiWr = regWr && (regAddr == `PMA_ADDR_SEL_HI);
	assign cmdLoWr = regWr && (regAddr == `PMA_ADDR_CMD_LO);
	assign wrLoWr  = regWr && (regAddr == `PMA_ADDR_WR_LO);
	assign wrHiWr  = regWr && (regAddr == `PMA_ADDR_WR_HI);

	// ----------------------------------------------------------------
	// Operation state decode
	// ----------------------------------------------------------------
	assign idle     = (state_q == pma_pkg::PMA_IDLE);
	assign busy     = !idle;
	assign scanning = (state_q == pma_pkg::PMA_SCAN);
	assign opLast   = (opCnt_q == `PMA_OP_LAST);

	// [RL16] scan start
	assign startScan  = idle && cmdScan_q;
	// [RL6] read start
	assign startRead  = idle && !cmdScan_q && cmdRead_q && !readTaken_q;
	// [RL13] write launch
	assign startWrite = idle && !cmdScan_q && !startRead && writePend_q;
	assign anyStart   = startScan || startRead || startWrite;

	// [RL7] read completion
	assign rdUpdate = opLast && (state_q == pma_pkg::PMA_READ || scanning);
	// [RL14] write completion
	assign phyWrEn  = opLast && (state_q == pma_pkg::PMA_WRITE);

	// ----------------------------------------------------------------
	// Selection and command registers
	// ----------------------------------------------------------------
	always_ff @(posedge mclk) begin
		if (rst) begin
			phyRegIndex_q <= '0;
			selReserved_q <= `PMA_SEL_RSV_RESET;
			cmdRead_q     <= 1'b0;
			cmdScan_q     <= 1'b0;
		end else begin
			// [RL4] index select
			if (selLoWr)
				phyRegIndex_q <= regWrData[`PMA_IDX_W-1:0];
			if (selHiWr)
				selReserved_q <= regWrData[`PMA_IDX_W-1:0];
			if (cmdLoWr) begin
				cmdRead_q <= regWrData[`PMA_CMD_READ_BIT];
				cmdScan_q <= regWrData[`PMA_CMD_SCAN_BIT];
			end
		end
	end

	// One read per setting of the read command
	always_ff @(posedge mclk) begin
		if (rst)
			readTaken_q <= 1'b0;
		// [RL7] read once
		else if (startRead)
			readTaken_q <= 1'b1;
		else if (!cmdRead_q)
			readTaken_q <= 1'b0;
	end

	// ----------------------------------------------------------------
	// Write data register
	// ----------------------------------------------------------------
	always_ff @(posedge mclk) begin
		if (rst) begin
			mgmtWriteData_q <= '0;
		end else begin
			if (wrLoWr)
				mgmtWriteData_q[7:0] <= regWrData;
			if (wrHiWr)
				mgmtWriteData_q[15:8] <= regWrData;
		end
	end

	// Pending launch, a new high-byte write wins over the clear
	always_ff @(posedge mclk) begin
		if (rst)
			writePend_q <= 1'b0;
		// [RL13] high byte launch
		else if (wrHiWr)
			writePend_q <= 1'b1;
		else if (startWrite)
			writePend_q <= 1'b0;
	end

	// ----------------------------------------------------------------
	// Operation sequencer
	// ----------------------------------------------------------------
	always_comb begin
		state_d = state_q;
		opCnt_d = opCnt_q + `PMA_CNT_W'(1);
		case (state_q)
			pma_pkg::PMA_IDLE: begin
				opCnt_d = '0;
				if (startScan)
					state_d = pma_pkg::PMA_SCAN;
				else if (startRead)
					state_d = pma_pkg::PMA_READ;
				else if (startWrite)
					state_d = pma_pkg::PMA_WRITE;
			end
			// [RL8] read then idle
			pma_pkg::PMA_READ: begin
				if (opLast)
					state_d = pma_pkg::PMA_IDLE;
			end
			pma_pkg::PMA_WRITE: begin
				if (opLast)
					state_d = pma_pkg::PMA_IDLE;
			end
			// [RL16] [RL20] repeat or end
			pma_pkg::PMA_SCAN: begin
				if (opLast) begin
					opCnt_d = '0;
					if (!cmdScan_q)
						state_d = pma_pkg::PMA_IDLE;
				end
			end
			default: begin
				state_d = pma_pkg::PMA_IDLE;
				opCnt_d = '0;
			end
		endcase
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			state_q <= pma_pkg::PMA_IDLE;
			opCnt_q <= '0;
		end else begin
			state_q <= state_d;
			opCnt_q <= opCnt_d;
		end
	end

	// [RL4] latch target
	always_ff @(posedge mclk) begin
		if (rst)
			opIndex_q <= '0;
		else if (anyStart)
			opIndex_q <= phyRegIndex_q;
	end

	// ----------------------------------------------------------------
	// Read data and validity
	// ----------------------------------------------------------------
	always_ff @(posedge mclk) begin
		if (rst)
			mgmtReadData_q <= '0;
		// [RL21] atomic update
		else if (rdUpdate)
			mgmtReadData_q <= phyRdData;
	end

	always_ff @(posedge mclk) begin
		if (rst)
			read_data_invalid_q <= 1'b0;
		// [RL17] invalid until first read
		else if (startScan || startRead)
			read_data_invalid_q <= 1'b1;
		else if (rdUpdate)
			read_data_invalid_q <= 1'b0;
	end

	// ----------------------------------------------------------------
	// PHY register space
	// ----------------------------------------------------------------
	// [RL1] separate space
	pma_phy_reg_file u_phy_regs (
		.mclk      (mclk),
		.rst       (rst),
		.phyIndex  (opIndex_q),
		.phyWrEn   (phyWrEn),
		.phyWrData (mgmtWriteData_q),
		.phyRdData (phyRdData),
		.phyHit    (phyHit)
	);

	// ----------------------------------------------------------------
	// Host read path
	// ----------------------------------------------------------------
	always_comb begin
		statusLo                     = '0;
		statusLo[`PMA_STAT_BUSY_BIT] = busy;
		statusLo[`PMA_STAT_SCAN_BIT] = scanning;
		statusLo[`PMA_STAT_NVAL_BIT] = read_data_invalid_q;
		cmdLo                        = '0;
		cmdLo[`PMA_CMD_READ_BIT]     = cmdRead_q;
		cmdLo[`PMA_CMD_SCAN_BIT]     = cmdScan_q;
	end

	// [RL10] [RL18] independent byte reads
	always_comb begin
		case (regAddr)
			`PMA_ADDR_SEL_LO:  rdByte = {3'h0, phyRegIndex_q};
			`PMA_ADDR_SEL_HI:  rdByte = {3'h0, selReserved_q};
			`PMA_ADDR_CMD_LO:  rdByte = cmdLo;
			`PMA_ADDR_STAT_LO: rdByte = statusLo;
			`PMA_ADDR_WR_LO:   rdByte = mgmtWriteData_q[7:0];
			`PMA_ADDR_WR_HI:   rdByte = mgmtWriteData_q[15:8];
			`PMA_ADDR_RD_LO:   rdByte = mgmtReadData_q[7:0];
			`PMA_ADDR_RD_HI:   rdByte = mgmtReadData_q[15:8];
			default:           rdByte = 8'h00;
		endcase
	end

	always_ff @(posedge mclk) begin
		if (rst)
			regRdData_q <= 8'h00;
		else if (regRd)
			regRdData_q <= rdByte;
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);

	property p_read_start;
		startRead |=> busy && (state_q == pma_pkg::PMA_READ) && read_data_invalid_q;
	endproperty
	a_read_start: assert property (p_read_start) // [RL6]
		else $error("read command did not start a busy read");

	property p_op_length;
		$fell(busy) |-> $past(opCnt_q) == `PMA_OP_LAST;
	endproperty
	a_op_length: assert property (p_op_length) // [RL8]
		else $error("busy cleared before the full operation time");

	property p_read_capture;
		rdUpdate |=> mgmtReadData_q == $past(phyRdData);
	endproperty
	a_read_capture: assert property (p_read_capture) // [RL7]
		else $error("read data not copied at read completion");

	property p_read_hold;
		!rdUpdate |=> $stable(mgmtReadData_q);
	endproperty
	a_read_hold: assert property (p_read_hold) // [RL21]
		else $error("read data changed without a read completion");

	property p_write_launch;
		idle && wrHiWr && !cmdScan_q && !cmdRead_q ##1 !cmdScan_q
			|=> state_q == pma_pkg::PMA_WRITE;
	endproperty
	a_write_launch: assert property (p_write_launch) // [RL13]
		else $error("high byte write did not launch a PHY write");

	property p_write_commit;
		phyWrEn && phyHit |=> phyRdData == $past(mgmtWriteData_q) && !busy;
	endproperty
	a_write_commit: assert property (p_write_commit) // [RL14]
		else $error("PHY register did not take the written word");

	property p_scan_repeat;
		scanning && opLast && cmdScan_q |=> scanning && opCnt_q == '0;
	endproperty
	a_scan_repeat: assert property (p_scan_repeat) // [RL16]
		else $error("scan did not continue with the next read");

	property p_scan_stop;
		scanning && !cmdScan_q && !cmdLoWr |-> ##[1:256] !busy;
	endproperty
	a_scan_stop: assert property (p_scan_stop) // [RL20]
		else $error("scan did not end after the command was cleared");

	property p_read_data_invalid_clear;
		rdUpdate |=> !read_data_invalid_q;
	endproperty
	a_read_data_invalid_clear: assert property (p_read_data_invalid_clear) // [RL17]
		else $error("invalid flag still set after a completed read");

	property p_index_latch;
		anyStart |=> opIndex_q == $past(phyRegIndex_q) && busy;
	endproperty
	a_index_latch: assert property (p_index_latch) // [RL4]
		else $error("operation does not target the selected register");

	c_read: cover property (startRead ##[1:300] rdUpdate);
	c_write: cover property (startWrite ##[1:300] phyWrEn);
	c_scan_stop: cover property (scanning && !cmdScan_q ##[1:300] idle);

endmodule // pma_mgmt_access

// file: inc/pma_params.svh
`ifndef PMA_PARAMS_SVH
`define PMA_PARAMS_SVH

// ----------------------------------------------------------------
// Clock and operation timing
// ----------------------------------------------------------------
`define PMA_CLK_PERIOD_NS   100
`define PMA_OP_TIME_NS      25600
`define PMA_OP_CYCLES       ((`PMA_OP_TIME_NS + `PMA_CLK_PERIOD_NS - 1) / `PMA_CLK_PERIOD_NS)
`define PMA_CNT_W           9
`define PMA_OP_LAST         9'(`PMA_OP_CYCLES - 1)

// ----------------------------------------------------------------
// Host register byte addresses
// ----------------------------------------------------------------
`define PMA_ADDR_SEL_LO     4'h0
`define PMA_ADDR_SEL_HI     4'h1
`define PMA_ADDR_CMD_LO     4'h2
`define PMA_ADDR_CMD_HI     4'h3
`define PMA_ADDR_STAT_LO    4'h4
`define PMA_ADDR_STAT_HI    4'h5
`define PMA_ADDR_WR_LO      4'h6
`define PMA_ADDR_WR_HI      4'h7
`define PMA_ADDR_RD_LO      4'h8
`define PMA_ADDR_RD_HI      4'h9

// ----------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------
`define PMA_IDX_W           5
`define PMA_SEL_RSV_RESET   5'h01
`define PMA_CMD_READ_BIT    0
`define PMA_CMD_SCAN_BIT    1
`define PMA_STAT_BUSY_BIT   0
`define PMA_STAT_SCAN_BIT   1
`define PMA_STAT_NVAL_BIT   2
`define PMA_UNIMPL_DATA     16'hffff

// ----------------------------------------------------------------
// PHY register addresses and reset values
// ----------------------------------------------------------------
`define PMA_PHY_SLOTS       8
`define PMA_PHY_CTRL1       5'h00
`define PMA_PHY_STAT1       5'h01
`define PMA_PHY_ANADV       5'h04
`define PMA_PHY_ANLPA       5'h05
`define PMA_PHY_ANEXP       5'h06
`define PMA_PHY_CTRL2       5'h11
`define PMA_PHY_STAT2       5'h1b
`define PMA_PHY_STAT3       5'h1f
`define PMA_RST_CTRL1       16'h1000
`define PMA_RST_STAT1       16'h7809
`define PMA_RST_ANADV       16'h01e1
`define PMA_RST_ANLPA       16'h0000
`define PMA_RST_ANEXP       16'h0000
`define PMA_RST_CTRL2       16'h0002
`define PMA_RST_STAT2       16'h0000
`define PMA_RST_STAT3       16'h0040

`endif

// file: inc/pma_pkg.sv
package pma_pkg;

	typedef enum logic [1:0] {
		PMA_IDLE,
		PMA_READ,
		PMA_WRITE,
		PMA_SCAN
	} pma_state_type;

endpackage

// file: design/pma_phy_reg_file.sv
`timescale 1ns/100ps
`include "pma_params.svh"

module pma_phy_reg_file (
	input  logic        mclk,
	input  logic        rst,
	input  logic [4:0]  phyIndex,
	input  logic        phyWrEn,
	input  logic [15:0] phyWrData,
	output logic [15:0] phyRdData,
	output logic        phyHit
);

	logic [15:0] mem [`PMA_PHY_SLOTS];
	logic [2:0]  slot;

	// ----------------------------------------------------------------
	// Address map
	// ----------------------------------------------------------------
	always_comb begin
		phyHit = 1'b1;
		case (phyIndex)
			`PMA_PHY_CTRL1: slot = 3'h0;
			`PMA_PHY_STAT1: slot = 3'h1;
			`PMA_PHY_ANADV: slot = 3'h2;
			`PMA_PHY_ANLPA: slot = 3'h3;
			`PMA_PHY_ANEXP: slot = 3'h4;
			`PMA_PHY_CTRL2: slot = 3'h5;
			`PMA_PHY_STAT2: slot = 3'h6;
			`PMA_PHY_STAT3: slot = 3'h7;
			default: begin
				slot   = 3'h0;
				phyHit = 1'b0;
			end
		endcase
	end

	// [RL2] unmapped reads ones
	assign phyRdData = phyHit ? mem[slot] : `PMA_UNIMPL_DATA;

	// ----------------------------------------------------------------
	// Storage
	// ----------------------------------------------------------------
	always_ff @(posedge mclk) begin
		if (rst) begin
			mem[0] <= `PMA_RST_CTRL1;
			mem[1] <= `PMA_RST_STAT1;
			mem[2] <= `PMA_RST_ANADV;
			mem[3] <= `PMA_RST_ANLPA;
			mem[4] <= `PMA_RST_ANEXP;
			mem[5] <= `PMA_RST_CTRL2;
			mem[6] <= `PMA_RST_STAT2;
			mem[7] <= `PMA_RST_STAT3;
		// [RL2] [RL11] full word write
		end else if (phyWrEn && phyHit) begin
			mem[slot] <= phyWrData;
		end
	end

	default clocking cbf @(posedge mclk); endclocking
	default disable iff (rst);

	property p_unmapped_write;
		phyWrEn && !phyHit ##1 $stable(phyIndex) |-> phyRdData == `PMA_UNIMPL_DATA;
	endproperty
	a_unmapped_write: assert property (p_unmapped_write) // [RL2]
		else $error("unmapped PHY address did not read all ones");

endmodule // pma_phy_reg_file

// file: tb/pma_host_model.sv
`timescale 1ns/100ps
`include "pma_params.svh"

module pma_host_model (
	input  logic       mclk,
	output logic [3:0] regAddr,
	output logic       regWr,
	output logic       regRd,
	output logic [7:0] regWrData
);
	// Expected read bytes, {byte address, value}
	logic [11:0] expQ[$];

	initial begin
		regAddr   = 4'hf;
		regWr     = 1'b0;
		regRd     = 1'b0;
		regWrData = 8'h00;
	end

	// ----------------------------------------------------------------
	// Byte cycles
	// ----------------------------------------------------------------
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge mclk);
		regAddr   <= a;
		regWrData <= d;
		regWr     <= 1'b1;
		@(posedge mclk);
		regAddr   <= ~a;
		regWrData <= ~d;
		regWr     <= 1'b0;
	endtask

	task automatic rd(input logic [3:0] a, input logic [7:0] e);
		expQ.push_back({a, e});
		@(posedge mclk);
		regAddr <= a;
		regRd   <= 1'b1;
		@(posedge mclk);
		regAddr <= ~a;
		regRd   <= 1'b0;
	endtask

	task automatic idle(input int n);
		repeat (n) @(posedge mclk);
	endtask

	// ----------------------------------------------------------------
	// Management sequences
	// ----------------------------------------------------------------
	// reserved field one
	task automatic sel(input logic [4:0] idx);
		wr(`PMA_ADDR_SEL_LO, {3'h0, idx});
		wr(`PMA_ADDR_SEL_HI, 8'h01);
	endtask

	task automatic busySpan(input logic [7:0] sRun, input logic [7:0] sEnd);
		idle(2);
		rd(`PMA_ADDR_STAT_LO, sRun);
		idle(246);
		rd(`PMA_ADDR_STAT_LO, sRun);
		idle(8);
		rd(`PMA_ADDR_STAT_LO, sEnd);
	endtask

	task automatic phyRead(input logic [4:0] idx, input logic [15:0] e, input logic hiFirst);
		sel(idx);
		wr(`PMA_ADDR_CMD_LO, 8'h01);
		busySpan(8'h05, 8'h00);
		wr(`PMA_ADDR_CMD_LO, 8'h00);
		if (hiFirst) begin
			rd(`PMA_ADDR_RD_HI, e[15:8]);
		end
		rd(`PMA_ADDR_RD_LO, e[7:0]);
		if (!hiFirst) begin
			rd(`PMA_ADDR_RD_HI, e[15:8]);
		end
	endtask

	task automatic phyWrite(input logic [4:0] idx, input logic [15:0] d);
		sel(idx);
		wr(`PMA_ADDR_WR_LO, d[7:0]);
		wr(`PMA_ADDR_WR_HI, d[15:8]);
		busySpan(8'h01, 8'h00);
	endtask

	task automatic phyScan(input logic [4:0] idx, input logic [15:0] e);
		sel(idx);
		wr(`PMA_ADDR_CMD_LO, 8'h02);
		busySpan(8'h07, 8'h03);
		rd(`PMA_ADDR_RD_LO, e[7:0]);
		idle(256);
		rd(`PMA_ADDR_RD_HI, e[15:8]);
		rd(`PMA_ADDR_STAT_LO, 8'h03);
		wr(`PMA_ADDR_CMD_LO, 8'h00);
		idle(262);
		rd(`PMA_ADDR_STAT_LO, 8'h00);
	endtask
endmodule // pma_host_model

// file: tb/tb_pma_mgmt_access.sv
`timescale 1ns/100ps
`include "pma_params.svh"

module tb_pma_mgmt_access;
	logic        mclk        = 1'b0;
	logic        rst         = 1'b1;
	logic [3:0]  regAddr;
	logic        regWr;
	logic        regRd;
	logic [7:0]  regWrData;
	logic [7:0]  regRdData_q;
	logic [15:0] lfsrState   = 16'h0059;
	logic [15:0] val;
	logic [11:0] note;
	int          badCount    = 0;
	int          totalChecks = 0;
	logic [4:0]  phyIdx[8]   = '{`PMA_PHY_CTRL1, `PMA_PHY_STAT1, `PMA_PHY_ANADV,
		`PMA_PHY_ANLPA, `PMA_PHY_ANEXP, `PMA_PHY_CTRL2, `PMA_PHY_STAT2, `PMA_PHY_STAT3};
	logic [15:0] phyRst[8]   = '{`PMA_RST_CTRL1, `PMA_RST_STAT1, `PMA_RST_ANADV,
		`PMA_RST_ANLPA, `PMA_RST_ANEXP, `PMA_RST_CTRL2, `PMA_RST_STAT2, `PMA_RST_STAT3};

	always #50 mclk = ~mclk;

	pma_mgmt_access dut_u (
		.mclk        (mclk),
		.rst         (rst),
		.regAddr     (regAddr),
		.regWr       (regWr),
		.regRd       (regRd),
		.regWrData   (regWrData),
		.regRdData_q (regRdData_q)
	);

	pma_host_model host_u (
		.mclk      (mclk),
		.regAddr   (regAddr),
		.regWr     (regWr),
		.regRd     (regRd),
		.regWrData (regWrData)
	);

	function automatic logic [15:0] lfsrNext(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction

	task automatic tallyAndFinish;
		if (badCount == 0 && totalChecks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	// ----------------------------------------------------------------
	// Read byte monitor
	// ----------------------------------------------------------------
	always @(posedge mclk) begin
		if (regRd === 1'b1) begin
			#1;
			totalChecks++;
			if (host_u.expQ.size() == 0) begin
				badCount++;
				$display("[ERR] regRdData_q expected none seen %h", regRdData_q);
			end else begin
				note = host_u.expQ.pop_front();
				if (regRdData_q !== note[7:0]) begin
					badCount++;
					$display("[ERR] regRdData_q byte %h expected %h seen %h",
						note[11:8], note[7:0], regRdData_q);
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	initial begin
		repeat (6) @(posedge mclk);
		rst <= 1'b0;
		for (int a = 0; a < 16; a++) begin
			if (a != 6 && a != 7) begin
				host_u.rd(4'(a), (a == 1) ? 8'h01 : 8'h00);
			end
		end
		host_u.wr(`PMA_ADDR_STAT_LO, 8'hff);
		host_u.wr(`PMA_ADDR_CMD_HI, 8'hff);
		host_u.wr(4'hd, 8'hff);
		host_u.rd(`PMA_ADDR_STAT_LO, 8'h00);
		host_u.rd(`PMA_ADDR_CMD_HI, 8'h00);
		host_u.rd(4'hd, 8'h00);
		for (int i = 0; i < 8; i++) begin
			host_u.phyRead(phyIdx[i], phyRst[i], i[0]);
		end
		host_u.phyRead(5'h13, 16'hffff, 1'b0);
		val = lfsrNext(lfsrState);
		lfsrState = val;
		host_u.phyWrite(`PMA_PHY_ANADV, val);
		host_u.phyRead(`PMA_PHY_ANADV, val, 1'b1);
		host_u.phyWrite(5'h07, ~val);
		host_u.rd(`PMA_ADDR_RD_LO, val[7:0]);
		host_u.rd(`PMA_ADDR_RD_HI, val[15:8]);
		host_u.phyRead(5'h07, 16'hffff, 1'b1);
		val = lfsrNext(lfsrState);
		lfsrState = val;
		host_u.phyWrite(`PMA_PHY_CTRL1, val);
		host_u.phyScan(`PMA_PHY_CTRL1, val);
		host_u.idle(4);
		if (host_u.expQ.size() != 0) begin
			badCount++;
			$display("[ERR] expQ expected 0 seen %0d", host_u.expQ.size());
		end
		tallyAndFinish();
	end

	initial begin
		repeat (12000) @(posedge mclk);
		badCount++;
		$display("[ERR] run expected done seen hang");
		tallyAndFinish();
	end
endmodule // tb_pma_mgmt_access
